//--- dual_wiper_map.vh
`ifndef DUAL_WIPER_MAP_VH
`define DUAL_WIPER_MAP_VH

// frame layout: two selector bits then eight tap bits, msb first
`define FRAME_BITS 10
`define TAP_BITS 8
`define SEL_MSB 9
`define SEL_LSB 8
`define TAP_MSB 7
`define TAP_LSB 0

// selector encodings
`define SEL_FIRST 2'b00
`define SEL_SECOND 2'b01
`define SEL_BOTH 2'b11

// midscale after power-on
`define WIPER_RESET 8'h80

// bit counter saturates here, so long frames still keep the last ten bits
`define CNT_BITS 4
`define CNT_FULL 4'hA

`endif

//--- dual_wiper_serial_loader.v
`timescale 1ns/1ns
`include "dual_wiper_map.vh"

// Behaviour
// RULE1: receive-only port of chip select, data in, serial clock; no data output.
// RULE2: while select low, shift data in on every serial clock rising edge.
// RULE3: on select rising, last ten shifted bits go to addressed register.
// RULE4: loaded tap value drives wiper output immediately, no further command.
// RULE5: master keeps select low whole frame; early rise ends the transfer.
// RULE6: frame is selector first (00 A, 01 B, 11 both), then tap msb first.
// RULE7: addressed wiper moves at the rising edge of chip select.
// RULE8: tap code 00h nearest low terminal, FFh nearest high, linear between.
// RULE9: after reset both wiper registers hold midscale 80h.
// RULE10: 256 taps per string; register value maps one-to-one onto a tap.
// RULE11: separate register per wiper; writing one leaves the other unchanged.
// RULE12: chip select is active low; frame in progress only while low.
// RULE13: selector code 10 leaves both wiper registers unchanged.
// RULE14: fewer than ten clock edges in a frame leaves both wipers unchanged.
module dual_wiper_serial_loader (
    input wire core_clk_i, // system clock, 25 MHz
    input wire srst_i, // synchronous reset, active high
    input wire cs_n_i, // chip select pin, active low
    input wire din_i, // serial data pin
    input wire sclk_i, // serial clock pin
    output wire [7:0] wiper_tap_first_o, // tap of first string, 0 = low end
    output wire [7:0] wiper_tap_second_o // tap of second string, 0 = low end
);

    // pin synchronisers; first stage is read only by the second
    reg [1:0] cs_sync;
    reg [1:0] din_sync;
    reg [1:0] sclk_sync;

    // previous second-stage levels, one per edge detector
    reg cs_prev;
    reg sclk_prev;

    // shift register keeps the ten newest bits; older ones fall off
    reg [`FRAME_BITS-1:0] shift_reg;
    reg [`FRAME_BITS-1:0] next_shift_reg;

    // edges seen in this frame; saturates so a long frame cannot wrap
    reg [`CNT_BITS-1:0] bit_cnt;
    reg [`CNT_BITS-1:0] next_bit_cnt;

    // frame phases, one-hot: select high, under ten edges, ten or more
    localparam [2:0] PH_IDLE = 3'h1;
    localparam [2:0] PH_SHORT = 3'h2;
    localparam [2:0] PH_FULL = 3'h4;
    reg [2:0] frame_phase;
    reg [2:0] next_frame_phase;

    // wiper tap registers, one per resistor string
    reg [`TAP_BITS-1:0] wiper_tap_first;
    reg [`TAP_BITS-1:0] wiper_tap_second;

    // values the tap registers take at the next clock edge
    reg [`TAP_BITS-1:0] next_wiper_tap_first;
    reg [`TAP_BITS-1:0] next_wiper_tap_second;

    // rising edge of a synchronised level against its previous sample
    function rise_of(input now_level, input last_level);
        rise_of = now_level & ~last_level;
    endfunction

    // tap code field of a received frame
    function [`TAP_BITS-1:0] tap_field(input [`FRAME_BITS-1:0] frame);
        tap_field = frame[`TAP_MSB:`TAP_LSB];
    endfunction

    // selector reaches the first string: its own code or write-both
    function hits_first(input [1:0] sel);
        hits_first = (sel == `SEL_FIRST) || (sel == `SEL_BOTH);
    endfunction

    // selector reaches the second string; code 10 reaches neither
    function hits_second(input [1:0] sel);
        hits_second = (sel == `SEL_SECOND) || (sel == `SEL_BOTH); // RULE13
    endfunction

    // frame status; sclk needs one core clock sample low, then one high, to be seen
    wire cs_low = ~cs_sync[1]; // RULE12
    wire sclk_rise = rise_of(sclk_sync[1], sclk_prev);
    wire cs_rise = rise_of(cs_sync[1], cs_prev);
    wire [1:0] pot_select_bits = shift_reg[`SEL_MSB:`SEL_LSB];

    // counter end points: saturated count, and the edge that reaches it
    wire count_done = (bit_cnt == `CNT_FULL);
    wire tenth_edge = sclk_rise && (bit_cnt == (`CNT_FULL - 4'h1));
    wire frame_full = (frame_phase == PH_FULL);

    // a frame loads only when select rises after at least ten edges
    wire load_strobe = cs_rise & frame_full; // RULE3 RULE5 RULE7 RULE14
    wire load_first = load_strobe & hits_first(pot_select_bits); // RULE6 RULE11
    wire load_second = load_strobe & hits_second(pot_select_bits); // RULE6 RULE11

    // chip select synchroniser; resets high so reset shows no frame
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            cs_sync <= 2'b11;
        end else begin
            cs_sync <= {cs_sync[0], cs_n_i}; // RULE1
        end
    end

    // data synchroniser; same depth as the clock path, so setup carries over
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            din_sync <= 2'b00;
        end else begin
            din_sync <= {din_sync[0], din_i};
        end
    end

    // serial clock synchroniser; resets low, the parked clock level
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            sclk_sync <= 2'b00;
        end else begin
            sclk_sync <= {sclk_sync[0], sclk_i};
        end
    end

    // edge history; seeded at idle levels so no false edge after reset
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            cs_prev <= 1'b1;
            sclk_prev <= 1'b0;
        end else begin
            cs_prev <= cs_sync[1];
            sclk_prev <= sclk_sync[1];
        end
    end

    // next shift register and edge count
    always @* begin
        next_shift_reg = shift_reg;
        next_bit_cnt = bit_cnt;
        if (!cs_low) begin
            next_bit_cnt = {`CNT_BITS{1'b0}}; // fresh count for next frame
        end else if (sclk_rise) begin
            next_shift_reg = {shift_reg[`FRAME_BITS-2:0], din_sync[1]}; // RULE2 RULE6
            if (!count_done) begin
                next_bit_cnt = bit_cnt + {{(`CNT_BITS-1){1'b0}}, 1'b1};
            end
        end
    end

    // shift and count registers; shift contents survive select high
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            shift_reg <= {`FRAME_BITS{1'b0}};
            bit_cnt <= {`CNT_BITS{1'b0}};
        end else begin
            shift_reg <= next_shift_reg;
            bit_cnt <= next_bit_cnt;
        end
    end

    // next frame phase; a select rise always returns to idle
    always @* begin
        next_frame_phase = frame_phase;
        case (frame_phase)
            PH_IDLE: begin
                if (cs_low && tenth_edge) begin
                    next_frame_phase = PH_FULL;
                end else if (cs_low) begin
                    next_frame_phase = PH_SHORT;
                end
            end
            PH_SHORT: begin
                if (!cs_low) begin
                    next_frame_phase = PH_IDLE;
                end else if (tenth_edge) begin
                    next_frame_phase = PH_FULL;
                end
            end
            PH_FULL: begin
                if (!cs_low) begin
                    next_frame_phase = PH_IDLE;
                end
            end
            default: begin
                next_frame_phase = PH_IDLE;
            end
        endcase
    end

    // phase register
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            frame_phase <= PH_IDLE;
        end else begin
            frame_phase <= next_frame_phase;
        end
    end

    // next tap values; an unaddressed wiper keeps its code
    always @* begin
        next_wiper_tap_first = wiper_tap_first; // RULE11
        next_wiper_tap_second = wiper_tap_second; // RULE11
        if (load_first) begin
            next_wiper_tap_first = tap_field(shift_reg);
        end
        if (load_second) begin
            next_wiper_tap_second = tap_field(shift_reg);
        end
    end

    // tap registers; a new code is live one cycle after the strobe
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            wiper_tap_first <= `WIPER_RESET; // RULE9
            wiper_tap_second <= `WIPER_RESET; // RULE9
        end else begin
            wiper_tap_first <= next_wiper_tap_first; // RULE7
            wiper_tap_second <= next_wiper_tap_second; // RULE7
        end
    end

    // registers drive the tap selectors directly, code equals tap index
    assign wiper_tap_first_o = wiper_tap_first; // RULE4 RULE8 RULE10
    assign wiper_tap_second_o = wiper_tap_second; // RULE4 RULE8 RULE10

endmodule // dual_wiper_serial_loader

//--- dual_wiper_chk.sv
`timescale 1ns/1ns
module dual_wiper_chk (
    input wire core_clk_i, // system clock
    input wire srst_i, // sync reset
    input wire cs_n_i, // select pin
    input wire din_i, // data pin
    input wire sclk_i, // serial clock pin
    input wire [7:0] wiper_tap_first_o, // tap a
    input wire [7:0] wiper_tap_second_o // tap b
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    // taps must leave reset at midscale
    property p_mid; $fell(srst_i) |-> wiper_tap_first_o == 8'h80 && wiper_tap_second_o == 8'h80; endproperty
    a_mid: assert property (p_mid) else $error("tap not midscale after reset");
    // idle bus: six high samples outlast any load still in flight
    property p_idle;
        cs_n_i [*6] ##0 !$past(srst_i) |-> $stable(wiper_tap_first_o) && $stable(wiper_tap_second_o);
    endproperty
    a_idle: assert property (p_idle) else $error("tap moved with select idle");
    // no tap moves mid frame, only on select release
    property p_busy;
        !cs_n_i [*5] ##0 !$past(srst_i) |-> $stable(wiper_tap_first_o) && $stable(wiper_tap_second_o);
    endproperty
    a_busy: assert property (p_busy) else $error("tap moved inside a frame");
    // a load shows only once select has stood high for three samples
    property p_late_a;
        !$past(srst_i) && $changed(wiper_tap_first_o) |-> $past(cs_n_i, 3) && $past(cs_n_i, 1);
    endproperty
    a_late_a: assert property (p_late_a) else $error("first tap moved before select rise");
    property p_late_b;
        !$past(srst_i) && $changed(wiper_tap_second_o) |-> $past(cs_n_i, 3) && $past(cs_n_i, 1);
    endproperty
    a_late_b: assert property (p_late_b) else $error("second tap moved before select rise");
    // both taps move together only through write-both, so they agree
    property p_pair;
        $changed(wiper_tap_first_o) && $changed(wiper_tap_second_o) |-> wiper_tap_first_o == wiper_tap_second_o;
    endproperty
    a_pair: assert property (p_pair) else $error("both taps moved to different codes");
    c_a: cover property ($changed(wiper_tap_first_o));
    c_b: cover property ($changed(wiper_tap_second_o));
    c_frame: cover property (!cs_n_i ##1 cs_n_i);
endmodule // dual_wiper_chk

//--- spi_master_model.sv
`timescale 1ns/1ns
// serial master; clock parks low between frames
module spi_master_model (
    output logic cs_n_o = 1'b1, // select, active low
    output logic din_o = 1'b0, // data
    output logic sclk_o = 1'b0 // serial clock
);
    // n bits of f, msb first, 320 ns clock period
    task send(input logic [11:0] f, input int n);
        cs_n_o = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            din_o = f[i];
            #160 sclk_o = 1'b1;
            #160 sclk_o = 1'b0;
        end
        din_o = ~din_o; // stale data must not linger
        #160 cs_n_o = 1'b1;
    endtask
endmodule // spi_master_model

//--- dual_wiper_serial_loader_bench.sv
`timescale 1ns/1ns
module dual_wiper_serial_loader_bench;
    logic core_clk_i = 1'b0;
    logic srst_i = 1'b1;
    wire cs_n, din, sclk;
    wire [7:0] tap_a, tap_b;
    int err_total = 0;
    int n_tests = 0;
    // selector, tap, expected a, expected b
    logic [25:0] rows [4] = '{{2'b00, 8'h00, 8'h00, 8'h80}, {2'b01, 8'hFF, 8'h00, 8'hFF},
        {2'b11, 8'h5A, 8'h5A, 8'h5A}, {2'b10, 8'h33, 8'h5A, 8'h5A}};
    initial forever #20 core_clk_i = ~core_clk_i;
    spi_master_model bus (.cs_n_o(cs_n), .din_o(din), .sclk_o(sclk));
    dual_wiper_serial_loader dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .cs_n_i(cs_n), .din_i(din),
        .sclk_i(sclk), .wiper_tap_first_o(tap_a), .wiper_tap_second_o(tap_b));
    task chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    // load settles well inside eight cycles
    task frame(input logic [11:0] f, input int n, input logic [7:0] ea, input logic [7:0] eb);
        bus.send(f, n);
        #320;
        chk(tap_a, ea);
        chk(tap_b, eb);
    endtask
    task wrap_up;
        $display("tests %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge core_clk_i);
        #1 srst_i = 1'b0;
        chk(tap_a, 8'h80);
        chk(tap_b, 8'h80);
        repeat (3) @(posedge core_clk_i);
        #1;
        foreach (rows[i]) frame({2'b00, rows[i][25:16]}, 10, rows[i][15:8], rows[i][7:0]);
        frame(12'h03F, 6, 8'h5A, 8'h5A);
        frame(12'hC12, 12, 8'h12, 8'h5A);
        @(posedge core_clk_i) #1 srst_i = 1'b1;
        @(posedge core_clk_i) #1 srst_i = 1'b0;
        chk(tap_a, 8'h80);
        chk(tap_b, 8'h80);
        wrap_up();
    end
    // watchdog, run needs about 22 us
    initial begin
        #100000 err_total++;
        wrap_up();
    end
endmodule // dual_wiper_serial_loader_bench
bind dual_wiper_serial_loader dual_wiper_chk u_chk (.core_clk_i, .srst_i, .cs_n_i, .din_i, .sclk_i,
    .wiper_tap_first_o, .wiper_tap_second_o);
